// ---- core/rcm_pkg.sv ----
// Constants, register map and state encoding shared by the reset and clock manager.
package rcm_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] REG_IDX_CSR = 8'h26;
    localparam logic [7:0] REG_IDX_MISC2 = 8'h27;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CSR = {2'h0, REG_IDX_CSR, 2'h0};
    localparam logic [11:0] ADDR_MISC2 = {2'h0, REG_IDX_MISC2, 2'h0};

    // Clock control and status register fields.
    localparam int CSR_SMS_BIT = 7;
    localparam int CSR_CP_HI_BIT = 6;
    localparam int CSR_CP_LO_BIT = 5;
    localparam int CSR_RSVD_BIT = 4;
    localparam int CSR_TB_HI_BIT = 3;
    localparam int CSR_TB_LO_BIT = 2;
    localparam int CSR_OIE_BIT = 1;
    localparam int CSR_OIF_BIT = 0;
    localparam logic [7:0] CSR_RESET = 8'h00;

    // Second miscellaneous register fields.
    localparam int MISC2_MCO_BIT = 0;
    localparam logic [7:0] MISC2_RESET = 8'h00;

    // Divider ratios.
    localparam logic [5:0] DIV_NORMAL = 6'h02;
    localparam logic [5:0] DIV_SLOW_BASE = 6'h04;

    // Reset sequence lengths in CPU clock cycles.
    localparam int RESET_CPU_CYCLES = 4096;
    localparam int STAB_CPU_CYCLES = 4096;

    // Least external reset pulse: 1.5 CPU cycles, as numerator over denominator.
    localparam logic [7:0] PULSE_NUM = 8'h03;
    localparam int PULSE_DEN_SHIFT = 1;

    // Time-base periods in oscillator cycles.
    localparam int TB_PERIOD_0 = 32000;
    localparam int TB_PERIOD_1 = 64000;
    localparam int TB_PERIOD_2 = 160000;
    localparam int TB_PERIOD_3 = 400000;
    localparam int TB_CNT_W = 19;

    // Reset service routine vector address.
    localparam logic [15:0] RESET_VECTOR = 16'hFFFE;

    typedef enum logic [5:0] {
        ST_RUN = 6'b000001,
        ST_EXTWAIT = 6'b000010,
        ST_DRIVE = 6'b000100,
        ST_STAB = 6'b001000,
        ST_RELEASE = 6'b010000,
        ST_HALT = 6'b100000
    } seq_state_e;

endpackage

// ---- core/cpu_clock_divider.sv ----
// CPU clock divider that produces a one-cycle CPU tick from the oscillator.
`timescale 1ns/100ps
module cpu_clock_divider
    import rcm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Divider selection
    input wire logic slow_mode_select,
    input wire logic [1:0] cpu_prescale,
    // Tick out
    output logic cpu_tick,
    output logic [5:0] ratio
);
    import rcm_pkg::*;

    logic [5:0] ratio_q;
    logic [5:0] ratio_d;
    logic [4:0] cnt_q;

    always_comb begin
        if (slow_mode_select) begin
            ratio_d = DIV_SLOW_BASE << cpu_prescale;
        end else begin
            ratio_d = DIV_NORMAL;
        end
    end

    assign cpu_tick = ({1'b0, cnt_q} == (ratio_q - 6'h01));
    assign ratio = ratio_q;

    // A new ratio is loaded only when a full period has ended, so no CPU cycle is cut short.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_q <= 5'h00;
            ratio_q <= DIV_NORMAL;
        end else if (cpu_tick) begin
            cnt_q <= 5'h00;
            ratio_q <= ratio_d;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

endmodule // cpu_clock_divider

// ---- core/reset_and_clock_manager.sv ----
// Reset manager and main clock unit: reset sequencing, CPU clock, time base and clock out.
`timescale 1ns/100ps
module reset_and_clock_manager
    import rcm_pkg::*;
#(
    parameter int RESET_CYCLES = rcm_pkg::RESET_CPU_CYCLES,
    parameter int STAB_CYCLES = rcm_pkg::STAB_CPU_CYCLES,
    parameter int TB_P0 = rcm_pkg::TB_PERIOD_0,
    parameter int TB_P1 = rcm_pkg::TB_PERIOD_1,
    parameter int TB_P2 = rcm_pkg::TB_PERIOD_2,
    parameter int TB_P3 = rcm_pkg::TB_PERIOD_3
) (
    // Oscillator clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic [rcm_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Open-drain reset pin
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    // Reset sources
    input wire logic por_detect,
    input wire logic wdg_underflow,
    // CPU side
    output logic cpu_tick,
    output logic cpu_rst,
    output logic cpu_run,
    output logic vector_fetch,
    output logic [15:0] vector_addr,
    input wire logic halt_req,
    input wire logic wake_req,
    output logic halt_mode,
    output logic active_halt,
    output logic timebase_irq,
    // Clock-out pin
    output logic clk_out_pin,
    output logic clk_out_oe_n
);
    import rcm_pkg::*;

    seq_state_e state_q;
    seq_state_e state_d;

    logic rst_pin_meta_q;
    logic rst_pin_sync_q;
    logic por_meta_q;
    logic por_sync_q;
    logic [7:0] low_cnt_q;
    logic [7:0] pulse_thr;
    logic ext_req;

    logic src_internal_q;
    logic src_internal_d;
    logic [15:0] seq_cnt_q;
    logic seq_cnt_clr;
    logic halt_exit_q;
    logic halt_exit_d;
    logic active_halt_q;
    logic active_halt_d;
    logic vector_fetch_q;

    logic slow_mode_select_q;
    logic [1:0] cpu_prescale_q;
    logic [1:0] timebase_sel_q;
    logic timebase_irq_enable_q;
    logic timebase_irq_flag_q;
    logic clock_out_enable_q;
    logic [7:0] clock_ctrl_status_reg;
    logic [7:0] misc_control_two;

    logic [5:0] div_ratio;
    logic [1:0] tb_sel_act_q;
    logic [TB_CNT_W-1:0] tb_cnt_q;
    logic [TB_CNT_W-1:0] tb_last;
    logic tb_event;
    logic clk_out_q;

    logic hit_csr;
    logic hit_misc;
    logic apb_setup;
    logic apb_wr;
    logic apb_rd;
    logic csr_read_clear;
    logic [31:0] prdata_q;
    logic reset_active;
    logic wake;

    cpu_clock_divider u_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .slow_mode_select(slow_mode_select_q),
        .cpu_prescale(cpu_prescale_q),
        .cpu_tick(cpu_tick),
        .ratio(div_ratio)
    );

    // Pin and power-on detector come from outside the clock domain.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rst_pin_meta_q <= 1'b1;
            rst_pin_sync_q <= 1'b1;
            por_meta_q <= 1'b0;
            por_sync_q <= 1'b0;
        end else begin
            rst_pin_meta_q <= rst_pin_in;
            rst_pin_sync_q <= rst_pin_meta_q;
            por_meta_q <= por_detect;
            por_sync_q <= por_meta_q;
        end
    end

    // The threshold follows the live divider so slow mode stretches the least pulse too.
    assign pulse_thr = (PULSE_NUM * {2'h0, div_ratio}) >> PULSE_DEN_SHIFT;
    assign ext_req = (low_cnt_q >= pulse_thr);

    // Low samples are only counted while the pin is not being driven by us.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            low_cnt_q <= 8'h00;
        end else if (rst_pin_sync_q || !(state_q == ST_RUN || state_q == ST_HALT)) begin
            low_cnt_q <= 8'h00;
        end else if (!ext_req) begin
            low_cnt_q <= low_cnt_q + 8'h01;
        end
    end

    assign wake = wake_req || (timebase_irq_flag_q && timebase_irq_enable_q);

    // Sequencer: optional wait for pin release, drive phase, stabilisation, pin release.
    always_comb begin
        state_d = state_q;
        src_internal_d = src_internal_q;
        halt_exit_d = halt_exit_q;
        active_halt_d = active_halt_q;
        seq_cnt_clr = 1'b0;
        case (state_q)
            ST_RUN, ST_HALT: begin
                if (por_sync_q || wdg_underflow) begin
                    state_d = ST_DRIVE;
                    src_internal_d = 1'b1;
                    seq_cnt_clr = 1'b1;
                    active_halt_d = 1'b0;
                end else if (ext_req) begin
                    state_d = ST_EXTWAIT;
                    src_internal_d = 1'b0;
                    active_halt_d = 1'b0;
                end else if (state_q == ST_RUN && halt_req) begin
                    state_d = ST_HALT;
                    active_halt_d = timebase_irq_enable_q;
                end else if (state_q == ST_HALT && wake) begin
                    state_d = ST_STAB;
                    halt_exit_d = 1'b1;
                    seq_cnt_clr = 1'b1;
                    active_halt_d = 1'b0;
                end
            end
            ST_EXTWAIT: begin
                seq_cnt_clr = 1'b1;
                if (rst_pin_sync_q) begin
                    state_d = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (cpu_tick && seq_cnt_q == 16'(RESET_CYCLES - 1)) begin
                    state_d = ST_STAB;
                    halt_exit_d = 1'b0;
                    seq_cnt_clr = 1'b1;
                end
            end
            ST_STAB: begin
                if (cpu_tick && seq_cnt_q == 16'(STAB_CYCLES - 1)) begin
                    // A halt exit ends here: stabilise is its only phase; every reset, power-on, watchdog or external, goes on to release.
                    state_d = halt_exit_q ? ST_RUN : ST_RELEASE;
                    halt_exit_d = 1'b0;
                    seq_cnt_clr = 1'b1;
                end
            end
            ST_RELEASE: begin
                // An external hold at the end of power-on reset keeps the CPU in reset here.
                if (rst_pin_sync_q && !por_sync_q) begin
                    state_d = ST_RUN;
                    src_internal_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_DRIVE;
                src_internal_d = 1'b1;
                seq_cnt_clr = 1'b1;
            end
        endcase
    end

    // After nrst the block behaves as a power-on reset.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= ST_DRIVE;
            src_internal_q <= 1'b1;
            halt_exit_q <= 1'b0;
            active_halt_q <= 1'b0;
        end else begin
            state_q <= state_d;
            src_internal_q <= src_internal_d;
            halt_exit_q <= halt_exit_d;
            active_halt_q <= active_halt_d;
        end
    end

    // Phase lengths count CPU cycles, not oscillator cycles.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            seq_cnt_q <= 16'h0000;
        end else if (seq_cnt_clr) begin
            seq_cnt_q <= 16'h0000;
        end else if (cpu_tick) begin
            seq_cnt_q <= seq_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            vector_fetch_q <= 1'b0;
        end else begin
            vector_fetch_q <= (state_q == ST_RELEASE) && (state_d == ST_RUN);
        end
    end

    assign reset_active = (state_q == ST_EXTWAIT) || (state_q == ST_DRIVE) ||
        (state_q == ST_STAB && !halt_exit_q) || (state_q == ST_RELEASE);
    assign cpu_rst = reset_active;
    assign cpu_run = (state_q == ST_RUN);
    assign halt_mode = (state_q == ST_HALT);
    assign active_halt = active_halt_q;
    assign vector_fetch = vector_fetch_q;
    assign vector_addr = RESET_VECTOR;
    // Open-drain: only ever pulls low, and only in the first two phases of an internal reset.
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe_n = !(src_internal_q && !halt_exit_q &&
        (state_q == ST_DRIVE || state_q == ST_STAB));

    // APB decode; the slave never inserts wait states.
    assign hit_csr = (paddr == ADDR_CSR);
    assign hit_misc = (paddr == ADDR_MISC2);
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite && (hit_csr || hit_misc);
    assign apb_rd = psel && penable && !pwrite && hit_csr;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_csr || hit_misc);
    assign prdata = prdata_q;

    assign clock_ctrl_status_reg = {slow_mode_select_q, cpu_prescale_q, 1'b0,
        timebase_sel_q, timebase_irq_enable_q, timebase_irq_flag_q};
    assign misc_control_two = {7'h00, clock_out_enable_q};

    // Read data is captured in setup, so the flag cleared is exactly the one software saw.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            if (hit_csr) begin
                prdata_q <= {24'h00_0000, clock_ctrl_status_reg};
            end else if (hit_misc) begin
                prdata_q <= {24'h00_0000, misc_control_two};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // Bit-set and bit-clear instructions read first, so they would lose a pending flag.
    assign csr_read_clear = apb_rd && prdata_q[CSR_OIF_BIT];

    // Control fields return to zero on every reset, internal ones included.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            slow_mode_select_q <= CSR_RESET[CSR_SMS_BIT];
            cpu_prescale_q <= CSR_RESET[CSR_CP_HI_BIT:CSR_CP_LO_BIT];
            timebase_sel_q <= CSR_RESET[CSR_TB_HI_BIT:CSR_TB_LO_BIT];
            timebase_irq_enable_q <= CSR_RESET[CSR_OIE_BIT];
        end else if (reset_active) begin
            slow_mode_select_q <= CSR_RESET[CSR_SMS_BIT];
            cpu_prescale_q <= CSR_RESET[CSR_CP_HI_BIT:CSR_CP_LO_BIT];
            timebase_sel_q <= CSR_RESET[CSR_TB_HI_BIT:CSR_TB_LO_BIT];
            timebase_irq_enable_q <= CSR_RESET[CSR_OIE_BIT];
        end else if (apb_wr && hit_csr) begin
            slow_mode_select_q <= pwdata[CSR_SMS_BIT];
            cpu_prescale_q <= pwdata[CSR_CP_HI_BIT:CSR_CP_LO_BIT];
            timebase_sel_q <= pwdata[CSR_TB_HI_BIT:CSR_TB_LO_BIT];
            timebase_irq_enable_q <= pwdata[CSR_OIE_BIT];
        end
    end

    // Flag: a period end in the same cycle as the clearing read keeps the flag set.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            timebase_irq_flag_q <= CSR_RESET[CSR_OIF_BIT];
        end else if (reset_active) begin
            timebase_irq_flag_q <= CSR_RESET[CSR_OIF_BIT];
        end else if (tb_event) begin
            timebase_irq_flag_q <= 1'b1;
        end else if (csr_read_clear) begin
            timebase_irq_flag_q <= 1'b0;
        end
    end

    assign timebase_irq = timebase_irq_flag_q && timebase_irq_enable_q;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            clock_out_enable_q <= MISC2_RESET[MISC2_MCO_BIT];
        end else if (reset_active) begin
            clock_out_enable_q <= MISC2_RESET[MISC2_MCO_BIT];
        end else if (apb_wr && hit_misc) begin
            clock_out_enable_q <= pwdata[MISC2_MCO_BIT];
        end
    end

    // Period decode of the selection actually running, not the one just written.
    always_comb begin
        case (tb_sel_act_q)
            2'h0: tb_last = TB_CNT_W'(TB_P0 - 1);
            2'h1: tb_last = TB_CNT_W'(TB_P1 - 1);
            2'h2: tb_last = TB_CNT_W'(TB_P2 - 1);
            2'h3: tb_last = TB_CNT_W'(TB_P3 - 1);
            default: tb_last = TB_CNT_W'(TB_P0 - 1);
        endcase
    end

    assign tb_event = (tb_cnt_q == tb_last);

    // Counting on the oscillator keeps the time base independent of slow mode.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tb_cnt_q <= '0;
            tb_sel_act_q <= CSR_RESET[CSR_TB_HI_BIT:CSR_TB_LO_BIT];
        end else if (reset_active) begin
            tb_cnt_q <= '0;
            tb_sel_act_q <= CSR_RESET[CSR_TB_HI_BIT:CSR_TB_LO_BIT];
        end else if (tb_event) begin
            tb_cnt_q <= '0;
            tb_sel_act_q <= timebase_sel_q;
        end else begin
            tb_cnt_q <= tb_cnt_q + TB_CNT_W'(1);
        end
    end

    // Toggling every cycle gives half the oscillator rate; it follows the enable's next value, so no stray high.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            clk_out_q <= 1'b0;
        end else if (reset_active) begin
            clk_out_q <= 1'b0;
        end else if (apb_wr && hit_misc) begin
            clk_out_q <= pwdata[MISC2_MCO_BIT] && !clk_out_q;
        end else if (clock_out_enable_q) begin
            clk_out_q <= !clk_out_q;
        end else begin
            clk_out_q <= 1'b0;
        end
    end

    assign clk_out_pin = clk_out_q;
    assign clk_out_oe_n = !clock_out_enable_q;

endmodule // reset_and_clock_manager

// ---- verification/rcm_monitor.sv ----
// Concurrent checks on the ports of the reset and clock manager.
`timescale 1ns/100ps
module rcm_monitor
    import rcm_pkg::*;
#(
    parameter int RESET_CYCLES = 8,
    parameter int STAB_CYCLES = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB
    input wire logic [rcm_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Reset pin and CPU side
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    input wire logic wdg_underflow,
    input wire logic cpu_rst,
    input wire logic cpu_run,
    input wire logic vector_fetch,
    input wire logic [15:0] vector_addr,
    input wire logic halt_req,
    input wire logic halt_mode,
    // Clock out
    input wire logic clk_out_pin,
    input wire logic clk_out_oe_n
);
    import rcm_pkg::*;

    // Two oscillator cycles per CPU tick; slack covers tick alignment and a slow ratio finishing its last period.
    localparam int LOW_MIN = 2 * (RESET_CYCLES + STAB_CYCLES) - 4;
    localparam int LOW_MAX = 2 * (RESET_CYCLES + STAB_CYCLES) + 8;
    int low_q;
    logic mapped;
    assign mapped = (paddr == ADDR_CSR) || (paddr == ADDR_MISC2);
    always_ff @(posedge sys_clk) begin
        if (!nrst || rst_pin_oe_n) begin
            low_q <= 0;
        end else begin
            low_q <= low_q + 1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    pin_low_span_a: assert property ($rose(rst_pin_oe_n) |-> low_q >= LOW_MIN && low_q <= LOW_MAX)
        else $error("reset pin low span out of range");
    pin_drive_a: assert property (!rst_pin_oe_n |-> !rst_pin_out && cpu_rst)
        else $error("pin driven outside reset");
    wdg_two_phase_a: assert property (cpu_run && wdg_underflow |=> cpu_rst && !rst_pin_oe_n)
        else $error("watchdog reset not started");
    reset_exit_a: assert property ($rose(nrst) |-> cpu_rst && !rst_pin_oe_n && clk_out_oe_n)
        else $error("state after reset release wrong");
    vector_pulse_a: assert property (vector_fetch |-> cpu_run && vector_addr == RESET_VECTOR ##1 !vector_fetch)
        else $error("vector fetch pulse wrong");
    halt_entry_a: assert property (cpu_run && halt_req && !wdg_underflow |=> halt_mode && !cpu_run)
        else $error("halt not entered");
    clk_out_idle_a: assert property (clk_out_oe_n |-> !clk_out_pin)
        else $error("clock out active while disabled");
    clk_out_half_a: assert property (!clk_out_oe_n && !$past(clk_out_oe_n)
        |-> clk_out_pin != $past(clk_out_pin))
        else $error("clock out not at half rate");
    addr_map_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("slave error does not match map");
    rsvd_zero_a: assert property (psel && penable && !pwrite && paddr == ADDR_CSR
        |-> prdata[CSR_RSVD_BIT] == 1'b0 && prdata[31:8] == 24'h00_0000)
        else $error("reserved read bits not zero");
endmodule // rcm_monitor

bind reset_and_clock_manager rcm_monitor #(.RESET_CYCLES(RESET_CYCLES), .STAB_CYCLES(STAB_CYCLES)) mon (
    .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pslverr(pslverr), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
    .wdg_underflow(wdg_underflow), .cpu_rst(cpu_rst), .cpu_run(cpu_run), .vector_fetch(vector_fetch),
    .vector_addr(vector_addr), .halt_req(halt_req), .halt_mode(halt_mode), .clk_out_pin(clk_out_pin),
    .clk_out_oe_n(clk_out_oe_n));

// ---- verification/ext_reset_model.sv ----
// Open-drain reset pin with pull-up and an external pull-down switch.
`timescale 1ns/100ps
module ext_reset_model (
    // External switch
    input wire logic ext_pull,
    // Device side of the pin
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    output logic rst_pin_in
);
    // Once both parties let go, the pull-up brings the pin high.
    assign rst_pin_in = (ext_pull || (!rst_pin_oe_n && !rst_pin_out)) ? 1'b0 : 1'b1;
endmodule // ext_reset_model

// ---- verification/reset_and_clock_manager_tb.sv ----
// Self-checking bench for the reset and clock manager.
`timescale 1ns/100ps
module reset_and_clock_manager_tb;
    import rcm_pkg::*;
    logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, rst_pin_in, rst_pin_out, rst_pin_oe_n;
    logic por_detect, wdg_underflow, cpu_tick, cpu_rst, cpu_run, vector_fetch, halt_req, wake_req;
    logic halt_mode, active_halt, timebase_irq, clk_out_pin, clk_out_oe_n, ext_pull, err, drove, b;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] vector_addr;
    int n_fail = 0, n_tests = 0, cyc = 0, vf_cnt = 0, t0, t1, t2, g, old;
    localparam int SEQ_CYC = 8;
    localparam int TB_LEN0 = 20, TB_LEN1 = 40, TB_LEN2 = 60, TB_LEN3 = 80;
    int per[4] = '{TB_LEN0, TB_LEN1, TB_LEN2, TB_LEN3};
    int tb_seq[4] = '{3, 1, 2, 0};
    reset_and_clock_manager #(.RESET_CYCLES(SEQ_CYC), .STAB_CYCLES(SEQ_CYC), .TB_P0(TB_LEN0),
        .TB_P1(TB_LEN1), .TB_P2(TB_LEN2), .TB_P3(TB_LEN3)) uut (.sys_clk(sys_clk), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .por_detect(por_detect), .wdg_underflow(wdg_underflow), .cpu_tick(cpu_tick), .cpu_rst(cpu_rst),
        .cpu_run(cpu_run), .vector_fetch(vector_fetch), .vector_addr(vector_addr), .halt_req(halt_req),
        .wake_req(wake_req), .halt_mode(halt_mode), .active_halt(active_halt), .timebase_irq(timebase_irq),
        .clk_out_pin(clk_out_pin), .clk_out_oe_n(clk_out_oe_n));
    ext_reset_model pin (.ext_pull(ext_pull), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .rst_pin_in(rst_pin_in));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (vector_fetch === 1'b1) vf_cnt <= vf_cnt + 1;
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_run();
        int n;
        n = 0;
        drove = 1'b0;
        do begin
            @(negedge sys_clk);
            n++;
            if (rst_pin_oe_n === 1'b0) drove = 1'b1;
        end while (cpu_run !== 1'b1 && n < 3000);
        chk("cpu_run", 1, cpu_run);
        repeat (3) @(negedge sys_clk);
    endtask
    task wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (timebase_irq !== 1'b1 && n < 500);
        t = cyc;
    endtask
    task tick_gap(output int gap);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (cpu_tick !== 1'b1 && n < 100);
        gap = 0;
        do begin
            @(negedge sys_clk);
            gap++;
        end while (cpu_tick !== 1'b1 && gap < 100);
    endtask
    task final_report();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
    initial begin
        {nrst, psel, penable, pwrite, por_detect, wdg_underflow, halt_req, wake_req, ext_pull} = 9'h000;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        wait_run();
        chk("fetches", 1, vf_cnt);
        chk("vector", 32'h0000FFFE, {16'h0, vector_addr});
        apb(1'b0, ADDR_CSR, 32'h0);
        chk("csr reset", 32'h0, rd & 32'hFE);
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped err", 1, err);
        apb(1'b1, ADDR_CSR, 32'hFF);
        apb(1'b0, ADDR_CSR, 32'h0);
        chk("csr bits", 32'hEE, rd & 32'hFE);
        chk("mapped err", 0, err);
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, ADDR_CSR, 32'h80 | (e << 5));
            tick_gap(g);
            tick_gap(g);
            chk("slow tick gap", 4 << e, g);
        end
        apb(1'b1, ADDR_CSR, 32'h0);
        tick_gap(g);
        tick_gap(g);
        chk("normal tick gap", 2, g);
        apb(1'b1, ADDR_CSR, 32'h02);
        apb(1'b0, ADDR_CSR, 32'h0);
        wait_irq(t0);
        apb(1'b0, ADDR_CSR, 32'h0);
        old = 0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CSR, (tb_seq[i] << 2) | 2);
            wait_irq(t1);
            apb(1'b0, ADDR_CSR, 32'h0);
            chk("flag", 1, rd[0]);
            @(negedge sys_clk);
            chk("irq cleared", 0, timebase_irq);
            wait_irq(t2);
            apb(1'b0, ADDR_CSR, 32'h0);
            chk("old period", per[old], t1 - t0);
            chk("new period", per[tb_seq[i]], t2 - t1);
            t0 = t2;
            old = tb_seq[i];
        end
        @(posedge sys_clk);
        halt_req <= 1'b1;
        @(posedge sys_clk);
        halt_req <= 1'b0;
        @(negedge sys_clk);
        chk("active halt", 1, active_halt);
        t1 = vf_cnt;
        wait_run();
        chk("halt exit fetch", t1, vf_cnt);
        apb(1'b1, ADDR_CSR, 32'h0);
        @(posedge sys_clk);
        halt_req <= 1'b1;
        @(posedge sys_clk);
        halt_req <= 1'b0;
        @(negedge sys_clk);
        chk("plain halt", 0, active_halt);
        repeat (40) @(negedge sys_clk);
        chk("asleep", 0, cpu_run);
        @(posedge sys_clk);
        wake_req <= 1'b1;
        @(posedge sys_clk);
        wake_req <= 1'b0;
        wait_run();
        apb(1'b1, ADDR_MISC2, 32'h1);
        @(negedge sys_clk);
        chk("clk out enable", 0, clk_out_oe_n);
        b = clk_out_pin;
        @(negedge sys_clk);
        chk("clk out toggle", !b, clk_out_pin);
        apb(1'b0, ADDR_MISC2, 32'h0);
        chk("misc2 readback", 1, rd);
        apb(1'b1, ADDR_CSR, 32'hAE);
        @(posedge sys_clk);
        wdg_underflow <= 1'b1;
        @(posedge sys_clk);
        wdg_underflow <= 1'b0;
        @(negedge sys_clk);
        chk("wdg pin low", 0, rst_pin_in);
        t1 = vf_cnt;
        wait_run();
        chk("wdg fetch", t1 + 1, vf_cnt);
        apb(1'b0, ADDR_CSR, 32'h0);
        chk("csr after wdg", 32'h0, rd & 32'hFE);
        apb(1'b0, ADDR_MISC2, 32'h0);
        chk("misc2 after wdg", 0, rd);
        @(posedge sys_clk);
        ext_pull <= 1'b1;
        repeat (2) @(posedge sys_clk);
        ext_pull <= 1'b0;
        repeat (10) @(negedge sys_clk);
        chk("short pulse", 1, cpu_run);
        @(posedge sys_clk);
        ext_pull <= 1'b1;
        repeat (8) @(posedge sys_clk);
        ext_pull <= 1'b0;
        @(negedge sys_clk);
        chk("pin reset", 1, cpu_rst);
        t1 = vf_cnt;
        wait_run();
        chk("pin not driven", 0, drove);
        chk("pin fetch", t1 + 1, vf_cnt);
        @(posedge sys_clk);
        ext_pull <= 1'b1;
        por_detect <= 1'b1;
        repeat (4) @(posedge sys_clk);
        por_detect <= 1'b0;
        repeat (100) @(negedge sys_clk);
        chk("held by pin", 0, cpu_run);
        @(posedge sys_clk);
        ext_pull <= 1'b0;
        wait_run();
        final_report();
    end
endmodule // reset_and_clock_manager_tb
